/* File: hdl/bmh_pkg.sv */
package bmh_pkg;
	localparam int unsigned X_W      = 4;
	localparam int unsigned Y_W      = 4;
	localparam int unsigned SUM_W    = 4;
	localparam int unsigned EXT_W    = 2;
	localparam int unsigned PROD_W   = X_W + Y_W;
	localparam int unsigned PAIR_W   = 2;
	localparam logic [SUM_W-1:0] PARTIAL_ZERO = 4'h0;
	localparam logic [PROD_W-1:0] PROD_RST   = 8'h00;
	localparam logic [X_W-1:0]   X_RST        = 4'h0;
	localparam logic [Y_W-1:0]   Y_RST        = 4'h0;

	typedef enum logic [1:0] {
		BMH_IDLE = 2'b00,
		BMH_ROW0 = 2'b01,
		BMH_ROW1 = 2'b10
	} bmh_state_e;
endpackage

/* File: hdl/bmh_pin_map.sv */
`timescale 1ns/1ps
module bmh_pin_map
	import bmh_pkg::*;
(
	input  logic [bmh_pkg::X_W-1:0]   i_x,          // Multiplicand, positive logic
	input  logic [bmh_pkg::Y_W-1:0]   i_y,          // Multiplier, positive logic
	input  logic                      i_row1,       // Second recoded pair selected
	input  logic                      i_neg,        // Negative-logic operation
	input  logic [bmh_pkg::SUM_W-1:0] i_partial,    // Pin-level partial product from row 0
	output logic [bmh_pkg::X_W-1:0]   o_x,          // Multiplicand pins
	output logic                      o_sign_copy,  // Sign copy pin
	output logic                      o_x_low_ext,  // Multiplicand low extension pin
	output logic                      o_lower,      // Multiplier lower neighbour pin
	output logic                      o_low,        // Multiplier low bit pin
	output logic                      o_high,       // Multiplier high bit pin
	output logic                      o_polarity,   // Polarity select pin
	output logic [bmh_pkg::SUM_W-1:0] o_partial,    // Partial product pins
	output logic                      o_carry_in    // Carry in pin
);
	import bmh_pkg::*;

	logic lower_l;
	logic low_l;
	logic high_l;

	always_comb begin
		lower_l = i_row1 ? i_y[1] : 1'b0; // RL16
		low_l   = i_row1 ? i_y[2] : i_y[0];
		high_l  = i_row1 ? i_y[3] : i_y[1];
		// Negative logic inverts every operand level, constants included
		o_x         = i_neg ? ~i_x : i_x; // RL6
		o_sign_copy = o_x[X_W-1]; // RL15
		o_x_low_ext = i_neg; // RL12
		o_lower     = lower_l ^ i_neg;
		o_low       = low_l ^ i_neg;
		o_high      = high_l ^ i_neg;
		o_polarity  = i_neg; // RL6
		// Row 1 takes the row 0 sum as the cell returned it, so no re-inversion
		o_partial   = i_row1 ? i_partial : (PARTIAL_ZERO ^ {SUM_W{i_neg}}); // RL13
		o_carry_in  = o_high; // RL11
	end
endmodule

/* File: hdl/bmh_host.sv */
`timescale 1ns/1ps
// Operation
// [RL1] Cell adds 0, X, 2X, -2X or -X per lower/low/high multiplier bits.
// [RL2] Cell treats the high multiplier bit as add (0) or subtract (1).
// [RL3] Cell single select is XOR of lower and low; double select on 110 or 001.
// [RL4] Cell uses a zero multiple when neither select is asserted.
// [RL5] Cell subtract control includes polarity so the zero case stays correct.
// [RL6] Polarity pin low for positive-logic operands, high with all operands inverted.
// [RL7] Cell select decoding is the same in both polarities.
// [RL8] Cell shifting array outputs inverted 0, X or 2X, low extension shifted in.
// [RL9] Cell complementer XNORs the array output with the subtract control.
// [RL10] Cell 4-bit lookahead adder adds multiple, partial product and carry in.
// [RL11] Carry in pin is tied to the high multiplier bit for subtraction.
// [RL12] Carry in follows the high bit and low extension is held at logic 0.
// [RL13] First row partial product is zero; later rows get the previous sum.
// [RL14] Cell outputs two extended sign bits atop four sum bits, forming a 6-bit signed result.
// [RL15] Sign copy follows the top multiplicand bit at the most significant end.
// [RL16] First row holds low extension and lower neighbour at logic 0.
// [RL17] Cell is purely combinational with no clock or reset.
module bmh_host
	import bmh_pkg::*;
(
	input  logic                       i_clock,                   // 100 MHz clock
	input  logic                       i_rst_n,                   // Synchronous reset
	input  logic                       i_start,                   // Start a multiply
	input  logic [bmh_pkg::X_W-1:0]    i_x,                       // Signed multiplicand
	input  logic [bmh_pkg::Y_W-1:0]    i_y,                       // Signed multiplier
	input  logic                       i_negative_logic,          // Run cell in negative logic
	input  logic [bmh_pkg::SUM_W-1:0]  i_cell_low_sum_bits,       // Cell sum bits 3..0
	input  logic [bmh_pkg::EXT_W-1:0]  i_cell_extended_sign_bits, // Cell sum bits 5..4
	output logic [bmh_pkg::X_W-1:0]    o_cell_x,                  // Multiplicand pins
	output logic                       o_cell_sign_copy_input,    // Sign copy pin
	output logic                       o_cell_x_low_ext,          // Multiplicand low ext pin
	output logic                       o_cell_mult_lower_neighbour, // Lower neighbour pin
	output logic                       o_cell_mult_low_bit,       // Multiplier low pin
	output logic                       o_cell_mult_high_bit,      // Multiplier high pin
	output logic                       o_cell_polarity,           // Polarity select pin
	output logic [bmh_pkg::SUM_W-1:0]  o_cell_partial,            // Partial product pins
	output logic                       o_cell_carry_in,           // Carry in pin
	output logic                       o_busy,                    // Multiply in progress
	output logic                       o_done,                    // Product valid pulse
	output logic [bmh_pkg::PROD_W-1:0] o_product                  // Signed product
);
	import bmh_pkg::*;

	bmh_state_e          state_q, state_d;
	logic [X_W-1:0]      x_q, x_d;
	logic [Y_W-1:0]      y_q, y_d;
	logic                neg_q, neg_d;
	logic [SUM_W-1:0]    partial_q, partial_d;
	logic [PROD_W-1:0]   product_q, product_d;
	logic                done_q, done_d;
	logic                busy_q, busy_d;
	logic [X_W-1:0]      pin_x_q, pin_x_d;
	logic                pin_sign_q, pin_sign_d;
	logic                pin_xlow_q, pin_xlow_d;
	logic                pin_lower_q, pin_lower_d;
	logic                pin_low_q, pin_low_d;
	logic                pin_high_q, pin_high_d;
	logic                pin_pol_q, pin_pol_d;
	logic [SUM_W-1:0]    pin_part_q, pin_part_d;
	logic                pin_cin_q, pin_cin_d;
	logic                take;
	logic [X_W-1:0]      use_x;
	logic [Y_W-1:0]      use_y;
	logic                use_neg;
	logic [X_W+EXT_W-1:0] cell_sum;

	// The cell answers combinationally, so its sum is sampled one clock after the pins move
	assign cell_sum = {i_cell_extended_sign_bits, i_cell_low_sum_bits} ^ {(X_W+EXT_W){neg_q}};
	assign take     = (state_q == BMH_IDLE) && i_start;
	assign use_x    = take ? i_x : x_q;
	assign use_y    = take ? i_y : y_q;
	assign use_neg  = take ? i_negative_logic : neg_q;

	always_comb begin
		state_d   = state_q;
		x_d       = x_q;
		y_d       = y_q;
		neg_d     = neg_q;
		partial_d = partial_q;
		product_d = product_q;
		done_d    = 1'b0;
		unique case (state_q)
			BMH_IDLE: begin
				if (i_start) begin
					x_d     = i_x;
					y_d     = i_y;
					neg_d   = i_negative_logic;
					state_d = BMH_ROW0;
				end
			end
			BMH_ROW0: begin
				// Two low bits leave the array; the upper four feed the next row
				product_d[1:0] = cell_sum[1:0];
				partial_d = {i_cell_extended_sign_bits, i_cell_low_sum_bits[3:2]}; // RL13
				state_d   = BMH_ROW1;
			end
			BMH_ROW1: begin
				product_d[PROD_W-1:2] = cell_sum;
				done_d  = 1'b1;
				state_d = BMH_IDLE;
			end
		endcase
		busy_d = (state_d != BMH_IDLE);
	end

	bmh_pin_map u_pin_map (
		.i_x         (use_x),
		.i_y         (use_y),
		.i_row1      (state_d == BMH_ROW1),
		.i_neg       (use_neg),
		.i_partial   (partial_d),
		.o_x         (pin_x_d),
		.o_sign_copy (pin_sign_d),
		.o_x_low_ext (pin_xlow_d),
		.o_lower     (pin_lower_d),
		.o_low       (pin_low_d),
		.o_high      (pin_high_d),
		.o_polarity  (pin_pol_d),
		.o_partial   (pin_part_d),
		.o_carry_in  (pin_cin_d)
	);

	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			state_q     <= BMH_IDLE;
			x_q         <= X_RST;
			y_q         <= Y_RST;
			neg_q       <= 1'b0;
			partial_q   <= PARTIAL_ZERO;
			product_q   <= PROD_RST;
			done_q      <= 1'b0;
			busy_q      <= 1'b0;
			pin_x_q     <= X_RST;
			pin_sign_q  <= 1'b0;
			pin_xlow_q  <= 1'b0;
			pin_lower_q <= 1'b0;
			pin_low_q   <= 1'b0;
			pin_high_q  <= 1'b0;
			pin_pol_q   <= 1'b0;
			pin_part_q  <= PARTIAL_ZERO;
			pin_cin_q   <= 1'b0;
		end else begin
			state_q     <= state_d;
			x_q         <= x_d;
			y_q         <= y_d;
			neg_q       <= neg_d;
			partial_q   <= partial_d;
			product_q   <= product_d;
			done_q      <= done_d;
			busy_q      <= busy_d;
			pin_x_q     <= pin_x_d;
			pin_sign_q  <= pin_sign_d;
			pin_xlow_q  <= pin_xlow_d;
			pin_lower_q <= pin_lower_d;
			pin_low_q   <= pin_low_d;
			pin_high_q  <= pin_high_d;
			pin_pol_q   <= pin_pol_d;
			pin_part_q  <= pin_part_d;
			pin_cin_q   <= pin_cin_d;
		end
	end

	assign o_cell_x                    = pin_x_q;
	assign o_cell_sign_copy_input      = pin_sign_q;
	assign o_cell_x_low_ext            = pin_xlow_q;
	assign o_cell_mult_lower_neighbour = pin_lower_q;
	assign o_cell_mult_low_bit         = pin_low_q;
	assign o_cell_mult_high_bit        = pin_high_q;
	assign o_cell_polarity             = pin_pol_q;
	assign o_cell_partial              = pin_part_q;
	assign o_cell_carry_in             = pin_cin_q;
	assign o_busy                      = busy_q;
	assign o_done                      = done_q;
	assign o_product                   = product_q;

	a_polarity_pin: assert property (@(posedge i_clock) disable iff (!i_rst_n) // RL6
		(state_q != BMH_IDLE) |-> (o_cell_polarity == neg_q)
		&& (o_cell_x == (x_q ^ {X_W{neg_q}})))
		else $error("polarity pin or operand inversion wrong");
	a_carry_tie: assert property (@(posedge i_clock) disable iff (!i_rst_n) // RL11
		(state_q != BMH_IDLE) |-> (o_cell_carry_in == o_cell_mult_high_bit))
		else $error("carry in not tied to high multiplier bit");
	a_low_ext_hold: assert property (@(posedge i_clock) disable iff (!i_rst_n) // RL12
		(state_q != BMH_IDLE) |-> (o_cell_x_low_ext == neg_q))
		else $error("low extension not held at logic 0");
	a_first_partial: assert property (@(posedge i_clock) disable iff (!i_rst_n) // RL13
		(state_q == BMH_ROW0) |-> (o_cell_partial == {SUM_W{neg_q}}))
		else $error("first row partial product not zero");
	a_partial_chain: assert property (@(posedge i_clock) disable iff (!i_rst_n) // RL13
		(state_q == BMH_ROW0) |=> (o_cell_partial
		== {$past(i_cell_extended_sign_bits), $past(i_cell_low_sum_bits[3:2])}))
		else $error("second row partial product not chained");
	a_sign_copy: assert property (@(posedge i_clock) disable iff (!i_rst_n) // RL15
		o_busy |-> (o_cell_sign_copy_input == o_cell_x[X_W-1]))
		else $error("sign copy differs from top multiplicand bit");
	a_first_neighbour: assert property (@(posedge i_clock) disable iff (!i_rst_n) // RL16
		(state_q == BMH_ROW0) |-> (o_cell_mult_lower_neighbour == neg_q)
		&& (o_cell_mult_low_bit == (y_q[0] ^ neg_q)))
		else $error("first row lower neighbour not logic 0");
	a_done_timing: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		take |=> (state_q == BMH_ROW0) ##1 (state_q == BMH_ROW1) ##1 o_done)
		else $error("multiply sequence out of step");
	a_carry_second_row: assert property (@(posedge i_clock) disable iff (!i_rst_n) // RL11
		(state_q == BMH_ROW1) |-> (o_cell_carry_in == (y_q[Y_W-1] ^ neg_q)))
		else $error("second row carry in not tied to multiplier sign bit");
	a_done_idle: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		o_done |-> !o_busy)
		else $error("done raised while still busy");

	c_pos_mult: cover property (@(posedge i_clock) disable iff (!i_rst_n)
		o_done && !neg_q);
	c_neg_mult: cover property (@(posedge i_clock) disable iff (!i_rst_n)
		o_done && neg_q);
	c_back_to_back: cover property (@(posedge i_clock) disable iff (!i_rst_n)
		o_done ##1 take);
	c_refused_start: cover property (@(posedge i_clock) disable iff (!i_rst_n)
		(state_q == BMH_ROW0) && i_start);
	c_row1_subtract: cover property (@(posedge i_clock) disable iff (!i_rst_n)
		(state_q == BMH_ROW1) && (o_cell_mult_high_bit != neg_q));
endmodule

/* File: test/bmh_cell_model.sv */
`timescale 1ns/1ps
module bmh_cell_model (
	input  logic [3:0] i_x,                  // Multiplicand pins
	input  logic       i_sign_copy,          // Sign copy pin
	input  logic       i_x_low_ext,          // Low extension pin
	input  logic       i_lower,              // Lower neighbour pin
	input  logic       i_low,                // Low multiplier pin
	input  logic       i_high,               // High multiplier pin
	input  logic       i_polarity,           // Polarity pin
	input  logic [3:0] i_partial,            // Partial product pins
	input  logic       i_carry_in,           // Carry in pin
	output logic [3:0] o_low_sum_bits,       // Sum bits 3..0
	output logic [1:0] o_extended_sign_bits, // Sum bits 5..4
	output logic       o_carry_out           // Adder carry out
);
	logic       pol, sel1, sel2, sub, ci;
	logic [3:0] xl, kl;
	logic [4:0] low;
	logic [5:0] mul, arr, add, sum;
	// Inverting all pins and results in negative logic is exact: the adder is self-dual
	always_comb begin
		pol  = i_polarity;
		xl   = i_x ^ {4{pol}};
		kl   = i_partial ^ {4{pol}};
		ci   = i_carry_in ^ pol;
		sel1 = i_lower ^ i_low;
		sel2 = (i_lower & i_low & ~i_high) | (~i_lower & ~i_low & i_high);
		sub  = i_high ^ pol;
		mul  = 6'h00;
		if (sel1) begin
			mul = {{2{i_sign_copy ^ pol}}, xl};
		end else if (sel2) begin
			mul = {i_sign_copy ^ pol, xl, i_x_low_ext ^ pol};
		end
		arr = ~mul;
		add = ~(arr ^ {6{sub}});
		low = {1'h0, kl} + {1'h0, add[3:0]} + {4'h0, ci};
		sum = {{2{kl[3]}}, kl} + add + {5'h00, ci};
	end
	assign o_low_sum_bits       = sum[3:0] ^ {4{pol}};
	assign o_extended_sign_bits = sum[5:4] ^ {2{pol}};
	assign o_carry_out          = low[4] ^ pol;
endmodule

/* File: test/test_bmh_host.sv */
`timescale 1ns/1ps
module test_bmh_host;
	import bmh_pkg::*;
	logic       i_clock          = 1'h0;
	logic       i_rst_n          = 1'h0;
	logic       i_start          = 1'h0;
	logic [3:0] i_x              = 4'h0;
	logic [3:0] i_y              = 4'h0;
	logic       i_negative_logic = 1'h0;
	logic [3:0] sum_lo, c_x, c_k;
	logic [1:0] sum_hi;
	logic       c_sc, c_xe, c_lw, c_lo, c_hi, c_p, c_ci, o_busy, o_done, pend;
	logic [7:0] o_product, exp_p;
	int         fails      = 0;
	int         n_compared = 0;

	bmh_host bmh_host_i (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_start(i_start),
		.i_x(i_x), .i_y(i_y), .i_negative_logic(i_negative_logic),
		.i_cell_low_sum_bits(sum_lo), .i_cell_extended_sign_bits(sum_hi),
		.o_cell_x(c_x), .o_cell_sign_copy_input(c_sc), .o_cell_x_low_ext(c_xe),
		.o_cell_mult_lower_neighbour(c_lw), .o_cell_mult_low_bit(c_lo),
		.o_cell_mult_high_bit(c_hi), .o_cell_polarity(c_p), .o_cell_partial(c_k),
		.o_cell_carry_in(c_ci), .o_busy(o_busy), .o_done(o_done), .o_product(o_product));
	bmh_cell_model bmh_cell_model_i (.i_x(c_x), .i_sign_copy(c_sc), .i_x_low_ext(c_xe),
		.i_lower(c_lw), .i_low(c_lo), .i_high(c_hi), .i_polarity(c_p), .i_partial(c_k),
		.i_carry_in(c_ci), .o_low_sum_bits(sum_lo), .o_extended_sign_bits(sum_hi),
		.o_carry_out());

	initial begin
		forever #5 i_clock = ~i_clock;
	end

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			fails++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic close_out;
		$display("compared %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// Result of the previous operation is judged in the cycle its done pulse stands
	task automatic settle_prev;
		#1;
		if (pend) begin
			check("product", {o_busy, o_done, o_product}, {2'h1, exp_p});
		end
		pend = 1'h0;
	endtask

	// Called at a rising edge; ends at the edge that raises done, so calls run back to back
	task automatic run(input logic [3:0] x, input logic [3:0] y, input logic n, input logic hold);
		int         v0;
		int         p;
		logic [3:0] xn;
		xn = x ^ {4{n}};
		v0 = $signed(x) * (int'(y[0]) - 2 * int'(y[1]));
		p = $signed(x) * $signed(y);
		i_x <= x;
		i_y <= y;
		i_negative_logic <= n;
		i_start <= 1'h1;
		settle_prev();
		@(posedge i_clock);
		i_start <= hold;
		i_x <= ~x;
		#1;
		check("row0", {o_busy, o_done, c_x, c_sc, c_xe, c_lw, c_lo, c_hi, c_p, c_ci, c_k},
			{2'h2, xn, xn[3], n, n, y[0] ^ n, y[1] ^ n, n, y[1] ^ n, {4{n}}});
		@(posedge i_clock);
		i_start <= 1'h0;
		#1;
		check("row1", {o_busy, o_done, c_x, c_lw, c_lo, c_hi, c_ci, c_k},
			{2'h2, xn, y[1] ^ n, y[2] ^ n, y[3] ^ n, y[3] ^ n, v0[5:2] ^ {4{n}}});
		@(posedge i_clock);
		exp_p = p[7:0];
		pend = 1'h1;
	endtask

	task automatic test_reset;
		repeat (12) @(posedge i_clock);
		i_rst_n <= 1'h1;
		#1;
		check("reset", {o_busy, o_done, o_product, c_k}, 16'h0000);
		repeat (2) @(posedge i_clock);
		$display("test reset finished");
	endtask

	// Every operand pair; equal operands also try a refused start while busy
	task automatic test_sweep(input logic n);
		for (int x = 0; x < 16; x++) begin
			for (int y = 0; y < 16; y++) begin
				run(4'(x), 4'(y), n, 1'(x == y));
			end
		end
		$display("test sweep polarity %0d finished", n);
	endtask

	initial begin
		pend = 1'h0;
		exp_p = 8'h00;
		test_reset();
		test_sweep(1'h0);
		test_sweep(1'h1);
		settle_prev();
		close_out();
	end

	// About 1600 cycles are needed; six times that cuts a hang short
	initial begin
		#100000;
		fails++;
		$display("watchdog expired");
		close_out();
	end
endmodule
